// ---- port_pin_function_mux_regs.svh ----
// Pin positions, reset values and address offsets of the port pin multiplexer
`ifndef PORT_PIN_FUNCTION_MUX_REGS_SVH
`define PORT_PIN_FUNCTION_MUX_REGS_SVH
`define PORT_BITS 8
`define NUM_PORTS 4
`define ADDR_BITS 20
`define LATCH_RESET 1'b1
`define PORT_ZERO 0
`define PORT_ONE 1
`define PORT_TWO 2
`define PORT_THREE 3
`define PORT_ZERO_ADDR_BASE 4
`define PORT_TWO_ADDR_BASE 12
`define P1_STROBE_BIT 0
`define P1_ADDR_LAST_BIT 3
`define P1_SERIAL_RX_BIT 4
`define P1_SERIAL_TX_BIT 5
`define P1_TIMER_COUNT_BIT 6
`define P1_TIMER_CTL_BIT 7
`endif

// ---- port_pin_function_mux_pkg.sv ----
// Types shared by the port pin multiplexer
package port_pin_function_mux_pkg;
	typedef enum logic [1:0] {
		MODE_QUASI,
		MODE_OPEN_DRAIN,
		MODE_PUSH_PULL,
		MODE_INPUT_ONLY
	} pinMode_t;
	typedef struct packed {
		logic enable;
		logic wide;
		logic addrPhase;
		logic dataDrive;
		logic writeHigh;
		logic [19:0] addr;
		logic [7:0] dataLow;
		logic [7:0] dataHigh;
	} extBus_t;
	typedef struct packed {
		logic programming;
		logic verify;
	} progCtl_t;
endpackage

// ---- port_pin_function_mux.sv ----
// Pin function multiplexer for ports 0 to 3 with latches and per-pin output modes
// Function
// - Ports 0-3: eight bits, configurable output type
// - Reset loads latches ones, quasi-bidirectional mode
// - Output mode held separately per pin
// - P1 bit0: address 0, or high strobe
// - P1 bits 1-3 drive address 1-3
// - P1 bit4 is serial B receive input
// - P1 bit5 is serial B transmit output
// - P1 pin: timer two count or clockout
// - P1 bit7 is timer two control input
// - Wide bus: P2 muxes high byte, A12-A19
// - Narrow bus: P2 address line count programmable
// - Verify: P2 takes low address byte in
// - Program/verify: P3 takes high address bits
// - Bus use: P0 muxes low byte, A4-A11
`timescale 1ns/1ns
`include "port_pin_function_mux_regs.svh"
module port_pin_function_mux
	import port_pin_function_mux_pkg::*;
#(
	parameter int PORT_WIDTH = `PORT_BITS,
	parameter int NUM_PORTS = `NUM_PORTS
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic latchWrEn,
	input wire logic [1:0] latchPort,
	input wire logic [PORT_WIDTH-1:0] latchData,
	input wire logic cfgWrEn,
	input wire logic [1:0] cfgPort,
	input wire logic [2:0] cfgPin,
	input wire pinMode_t cfgMode,
	input wire extBus_t extBus,
	input wire logic [3:0] p2AddrCount,
	input wire logic serialRxEnable,
	input wire logic serialTxEnable,
	input wire logic serialBTransmitOut,
	input wire logic timerCountEnable,
	input wire logic timerClockOutEnable,
	input wire logic timerClockOut,
	input wire logic timerControlEnable,
	input wire progCtl_t progCtl,
	input wire logic [NUM_PORTS*PORT_WIDTH-1:0] pinIn,
	output logic [NUM_PORTS*PORT_WIDTH-1:0] pinOut,
	output logic [NUM_PORTS*PORT_WIDTH-1:0] pinOe,
	output logic [NUM_PORTS*PORT_WIDTH-1:0] pinPullUp,
	output logic [NUM_PORTS*PORT_WIDTH-1:0] pinLevel,
	output logic [NUM_PORTS*PORT_WIDTH-1:0] portLatch,
	output pinMode_t pinMode [NUM_PORTS*PORT_WIDTH],
	output logic [PORT_WIDTH-1:0] busReadLow,
	output logic [PORT_WIDTH-1:0] busReadHigh,
	output logic [PORT_WIDTH-1:0] progAddrLow,
	output logic [PORT_WIDTH-1:0] progAddrHigh,
	output logic serialBReceiveIn,
	output logic timerTwoCountIn,
	output logic timerTwoControlIn
);
	localparam int NUM_PINS = NUM_PORTS * PORT_WIDTH;
	localparam int P1 = `PORT_ONE * PORT_WIDTH;
	localparam int P2 = `PORT_TWO * PORT_WIDTH;
	localparam int P3 = `PORT_THREE * PORT_WIDTH;

	logic progActive;
	assign progActive = progCtl.programming | progCtl.verify;

	genvar g;
	generate
		for (g = 0; g < NUM_PINS; g++) begin : gPin
			localparam int P = g / PORT_WIDTH;
			localparam int B = g % PORT_WIDTH;
			logic altActive;
			logic altDrive;
			logic altValue;
			logic next_out;
			logic next_oe;
			logic next_pull;

			// Port latch, ones after reset
			always_ff @(posedge sys_clk) begin
				if (!rst_b) begin
					portLatch[g] <= `LATCH_RESET;
				end else if (latchWrEn && latchPort == 2'(P)) begin
					portLatch[g] <= latchData[B];
				end
			end

			// Output mode of this pin alone
			always_ff @(posedge sys_clk) begin
				if (!rst_b) begin
					pinMode[g] <= MODE_QUASI;
				end else if (cfgWrEn && cfgPort == 2'(P) && cfgPin == 3'(B)) begin
					pinMode[g] <= cfgMode;
				end
			end

			// Alternate function selection, programming first, then bus, then peripherals
			always_comb begin
				altActive = 1'b0;
				altDrive = 1'b0;
				altValue = 1'b0;
				if (progActive) begin
					if (P == `PORT_THREE) begin
						altActive = 1'b1;
					end else if (P == `PORT_TWO && progCtl.verify) begin
						altActive = 1'b1;
					end
				end else if (P == `PORT_ZERO) begin
					if (extBus.enable) begin
						altActive = 1'b1;
						altDrive = extBus.addrPhase | extBus.dataDrive;
						altValue = extBus.addrPhase ? extBus.addr[`PORT_ZERO_ADDR_BASE+B] : extBus.dataLow[B];
					end
				end else if (P == `PORT_TWO) begin
					if (extBus.enable && extBus.wide) begin
						altActive = 1'b1;
						altDrive = extBus.addrPhase | extBus.dataDrive;
						altValue = extBus.addrPhase ? extBus.addr[`PORT_TWO_ADDR_BASE+B] : extBus.dataHigh[B];
					end else if (extBus.enable && 4'(B) < p2AddrCount) begin
						altActive = 1'b1;
						altDrive = 1'b1;
						altValue = extBus.addr[`PORT_TWO_ADDR_BASE+B];
					end
				end else if (P == `PORT_ONE) begin
					if (B == `P1_STROBE_BIT) begin
						if (extBus.enable) begin
							altActive = 1'b1;
							altDrive = 1'b1;
							altValue = extBus.wide ? extBus.writeHigh : extBus.addr[0];
						end
					end else if (B <= `P1_ADDR_LAST_BIT) begin
						if (extBus.enable) begin
							altActive = 1'b1;
							altDrive = 1'b1;
							altValue = extBus.addr[B];
						end
					end else if (B == `P1_SERIAL_RX_BIT) begin
						altActive = serialRxEnable;
					end else if (B == `P1_SERIAL_TX_BIT) begin
						altActive = serialTxEnable;
						altDrive = serialTxEnable;
						altValue = serialBTransmitOut;
					end else if (B == `P1_TIMER_COUNT_BIT) begin
						altActive = timerClockOutEnable | timerCountEnable;
						altDrive = timerClockOutEnable;
						altValue = timerClockOut;
					end else begin
						altActive = timerControlEnable;
					end
				end
			end

			// Pin drive from alternate function or from latch and mode
			always_comb begin
				next_out = portLatch[g];
				next_oe = 1'b0;
				next_pull = 1'b0;
				if (altActive) begin
					next_out = altValue;
					next_oe = altDrive;
				end else begin
					case (pinMode[g])
						MODE_QUASI: begin
							next_oe = ~portLatch[g];
							next_pull = 1'b1;
						end
						MODE_OPEN_DRAIN: begin
							next_oe = ~portLatch[g];
						end
						MODE_PUSH_PULL: begin
							next_oe = 1'b1;
						end
						MODE_INPUT_ONLY: begin
							next_oe = 1'b0;
						end
						default: begin
							next_oe = 1'b0;
						end
					endcase
				end
			end

			// Registered pin outputs and sampled pin level
			always_ff @(posedge sys_clk) begin
				if (!rst_b) begin
					pinOut[g] <= 1'b1;
					pinOe[g] <= 1'b0;
					pinPullUp[g] <= 1'b1;
					pinLevel[g] <= 1'b1;
				end else begin
					pinOut[g] <= next_out;
					pinOe[g] <= next_oe;
					pinPullUp[g] <= next_pull;
					pinLevel[g] <= pinIn[g];
				end
			end
		end
	endgenerate

	// Bus read data from ports 0 and 2
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			busReadLow <= '0;
			busReadHigh <= '0;
		end else begin
			busReadLow <= pinIn[PORT_WIDTH-1:0];
			busReadHigh <= pinIn[P2+PORT_WIDTH-1:P2];
		end
	end

	// Programming address inputs
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			progAddrLow <= '0;
			progAddrHigh <= '0;
		end else begin
			if (progCtl.verify) begin
				progAddrLow <= pinIn[P2+PORT_WIDTH-1:P2];
			end
			if (progActive) begin
				progAddrHigh <= pinIn[P3+PORT_WIDTH-1:P3];
			end
		end
	end

	// Peripheral inputs from port 1
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			serialBReceiveIn <= 1'b1;
			timerTwoCountIn <= 1'b0;
			timerTwoControlIn <= 1'b0;
		end else begin
			serialBReceiveIn <= serialRxEnable ? pinIn[P1+`P1_SERIAL_RX_BIT] : 1'b1;
			timerTwoCountIn <= timerCountEnable & pinIn[P1+`P1_TIMER_COUNT_BIT];
			timerTwoControlIn <= timerControlEnable & pinIn[P1+`P1_TIMER_CTL_BIT];
		end
	end

	// Checks
	AST_RESET_LATCH: assert property (@(posedge sys_clk) !rst_b |=> (&portLatch) && !(|pinOe))
		else $error("Latches or drives wrong after reset");
	AST_MODE_ONE_PIN: assert property (@(posedge sys_clk) disable iff (!rst_b)
		cfgWrEn && cfgPort == 2'(`PORT_ONE) && cfgPin == 3'd0 |=> pinMode[P1+1] == $past(pinMode[P1+1]))
		else $error("Mode write disturbed a neighbour pin");
	AST_STROBE_WIDE: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!progActive && extBus.enable && extBus.wide |=> pinOe[P1] && pinOut[P1] == $past(extBus.writeHigh))
		else $error("High strobe not on port 1 bit 0");
	AST_ADDR_NARROW: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!progActive && extBus.enable |=> pinOut[P1+3:P1+1] == $past(extBus.addr[3:1]))
		else $error("Address bits 1 to 3 wrong");
	AST_TX_PIN: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!progActive && serialTxEnable |=> pinOe[P1+`P1_SERIAL_TX_BIT] &&
		pinOut[P1+`P1_SERIAL_TX_BIT] == $past(serialBTransmitOut))
		else $error("Serial transmit not on port 1 bit 5");
	AST_P2_ADDR: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!progActive && extBus.enable && extBus.wide && extBus.addrPhase |=>
		pinOut[P2+PORT_WIDTH-1:P2] == $past(extBus.addr[19:12]) && (&pinOe[P2+PORT_WIDTH-1:P2]))
		else $error("Port 2 address phase wrong");
	AST_P0_ADDR: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!progActive && extBus.enable && extBus.addrPhase |=>
		pinOut[PORT_WIDTH-1:0] == $past(extBus.addr[11:4]))
		else $error("Port 0 address phase wrong");
	AST_PROG_HIGH: assert property (@(posedge sys_clk) disable iff (!rst_b)
		progActive |=> !(|pinOe[P3+PORT_WIDTH-1:P3]) ##1 progAddrHigh == $past(pinIn[P3+PORT_WIDTH-1:P3], 1)
		|| !$past(progActive))
		else $error("Port 3 not taken as programming address");
	AST_QUASI_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!progActive && !extBus.enable && pinMode[P2] == MODE_QUASI |=> pinOe[P2] == !$past(portLatch[P2]))
		else $error("Idle port 2 pin not following latch");
endmodule

// ---- pin_partner.sv ----
// Far-side pin model: external devices and programmer on the port pins
`timescale 1ns/1ns
module pin_partner (
	input wire logic sys_clk,
	input wire logic [31:0] pinOut,
	input wire logic [31:0] pinOe,
	input wire logic [31:0] pinPullUp,
	input wire logic [31:0] extOe,
	input wire logic [31:0] extVal,
	output logic [31:0] pinIn
);
	logic [31:0] noise = 32'haaaa_aaaa;
	// Undriven lines without pull-up wander every cycle
	always @(posedge sys_clk) begin
		noise <= ~noise;
	end
	// Programmer address bytes on ports 2 and 3 arrive through extVal
	always_comb begin
		for (int i = 0; i < 32; i++) begin
			pinIn[i] = pinOe[i] ? pinOut[i] : extOe[i] ? extVal[i] : pinPullUp[i] ? 1'b1 : noise[i];
		end
	end
endmodule

// ---- testbench.sv ----
// Self-checking bench for the port pin function multiplexer
`timescale 1ns/1ns
module testbench;
	import port_pin_function_mux_pkg::*;
	logic sys_clk = 1'b0, rst_b = 1'b0, latchWrEn = 1'b0, cfgWrEn = 1'b0;
	logic [1:0] latchPort = 2'h0, cfgPort = 2'h0;
	logic [7:0] latchData = 8'h00;
	logic [2:0] cfgPin = 3'h0;
	pinMode_t cfgMode = MODE_QUASI;
	extBus_t extBus = '0;
	progCtl_t progCtl = '0;
	logic [3:0] p2AddrCount = 4'h0;
	logic serialRxEnable = 1'b0, serialTxEnable = 1'b0, serialBTransmitOut = 1'b1;
	logic timerCountEnable = 1'b0, timerClockOutEnable = 1'b0, timerClockOut = 1'b1, timerControlEnable = 1'b0;
	logic [31:0] pinIn, pinOut, pinOe, pinPullUp, pinLevel, portLatch, extOe = 32'h0, extVal = 32'h0;
	pinMode_t pinMode [32];
	logic [7:0] busReadLow, busReadHigh, progAddrLow, progAddrHigh;
	logic serialBReceiveIn, timerTwoCountIn, timerTwoControlIn;
	int n_fail = 0, n_tests = 0;
	port_pin_function_mux dut (.sys_clk(sys_clk), .rst_b(rst_b), .latchWrEn(latchWrEn), .latchPort(latchPort),
		.latchData(latchData), .cfgWrEn(cfgWrEn), .cfgPort(cfgPort), .cfgPin(cfgPin), .cfgMode(cfgMode),
		.extBus(extBus), .p2AddrCount(p2AddrCount), .serialRxEnable(serialRxEnable),
		.serialTxEnable(serialTxEnable), .serialBTransmitOut(serialBTransmitOut),
		.timerCountEnable(timerCountEnable), .timerClockOutEnable(timerClockOutEnable),
		.timerClockOut(timerClockOut), .timerControlEnable(timerControlEnable), .progCtl(progCtl),
		.pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pinPullUp(pinPullUp), .pinLevel(pinLevel),
		.portLatch(portLatch), .pinMode(pinMode), .busReadLow(busReadLow), .busReadHigh(busReadHigh),
		.progAddrLow(progAddrLow), .progAddrHigh(progAddrHigh), .serialBReceiveIn(serialBReceiveIn),
		.timerTwoCountIn(timerTwoCountIn), .timerTwoControlIn(timerTwoControlIn));
	pin_partner far (.sys_clk(sys_clk), .pinOut(pinOut), .pinOe(pinOe), .pinPullUp(pinPullUp),
		.extOe(extOe), .extVal(extVal), .pinIn(pinIn));
	initial begin
		forever #25 sys_clk = ~sys_clk;
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic settle();
		repeat (3) @(posedge sys_clk);
		#1;
	endtask
	task automatic wrLatch(input logic [1:0] p, input logic [7:0] d);
		@(posedge sys_clk);
		latchWrEn <= 1'b1;
		latchPort <= p;
		latchData <= d;
		@(posedge sys_clk);
		latchWrEn <= 1'b0;
		settle();
	endtask
	task automatic wrMode(input logic [1:0] p, input logic [2:0] b, input pinMode_t m);
		@(posedge sys_clk);
		cfgWrEn <= 1'b1;
		cfgPort <= p;
		cfgPin <= b;
		cfgMode <= m;
		@(posedge sys_clk);
		cfgWrEn <= 1'b0;
		settle();
	endtask
	task automatic endTest(input string name);
		$display("test %s finished, mismatches %0d", name, n_fail);
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#(2000 * 50);
		n_fail++;
		complete_run();
	end
	initial begin
		repeat (12) @(posedge sys_clk);
		rst_b <= 1'b1;
		#1;
		chk("latches", 32'hffff_ffff, portLatch);
		chk("oe", 32'h0000_0000, pinOe);
		chk("pull", 32'hffff_ffff, pinPullUp);
		for (int i = 0; i < 32; i++) chk("mode", 32'(MODE_QUASI), 32'(pinMode[i]));
		endTest("reset");
		wrLatch(2'h1, 8'h5a);
		chk("p1 out", 32'h0000_005a, 32'(pinOut[15:8]));
		chk("p1 oe", 32'h0000_00a5, 32'(pinOe[15:8]));
		wrLatch(2'h2, 8'hfe);
		chk("p2 quasi oe", 32'h0000_0001, 32'(pinOe[23:16]));
		for (int m = 3; m >= 0; m--) begin
			wrMode(2'h1, 3'h3, pinMode_t'(m));
			chk("mode", 32'(m), 32'(pinMode[11]));
			chk("neighbour mode", 32'(MODE_QUASI), 32'(pinMode[10]));
			chk("oe", 32'(m == 2), 32'(pinOe[11]));
		end
		wrMode(2'h1, 3'h0, MODE_OPEN_DRAIN);
		chk("mode", 32'(MODE_OPEN_DRAIN), 32'(pinMode[8]));
		chk("neighbour mode", 32'(MODE_QUASI), 32'(pinMode[9]));
		endTest("latch and mode");
		@(posedge sys_clk);
		extBus <= '{enable: 1'b1, addrPhase: 1'b1, writeHigh: 1'b1, addr: 20'habcde, default: '0};
		p2AddrCount <= 4'h3;
		settle();
		chk("p1 addr", 32'h0000_000e, 32'(pinOut[11:8]));
		chk("p0 addr", 32'h0000_00cd, 32'(pinOut[7:0]));
		chk("p2 addr", 32'h0000_0003, 32'(pinOut[18:16]));
		chk("p2 oe", 32'h0000_0007, 32'(pinOe[23:16]));
		p2AddrCount <= 4'h5;
		settle();
		chk("p2 oe", 32'h0000_001f, 32'(pinOe[23:16]));
		extBus.wide <= 1'b1;
		settle();
		chk("strobe", 32'h0000_0001, 32'(pinOut[8]));
		chk("p2 addr", 32'h0000_00ab, 32'(pinOut[23:16]));
		extBus <= '{enable: 1'b1, wide: 1'b1, dataDrive: 1'b1, dataLow: 8'hc3, dataHigh: 8'h3c, default: '0};
		settle();
		chk("p2 data", 32'h0000_003c, 32'(pinOut[23:16]));
		chk("p0 data", 32'h0000_00c3, 32'(pinOut[7:0]));
		extBus <= '0;
		settle();
		chk("p1 back", 32'h0000_005a, 32'(pinOut[15:8]));
		endTest("external bus");
		extOe <= 32'h0000_d000;
		extVal <= 32'h0000_c000;
		serialRxEnable <= 1'b1;
		serialTxEnable <= 1'b1;
		timerCountEnable <= 1'b1;
		timerControlEnable <= 1'b1;
		settle();
		chk("rx", 32'h0, 32'(serialBReceiveIn));
		chk("tx", 32'h1, 32'(pinOut[13]));
		chk("count", 32'h1, 32'(timerTwoCountIn));
		chk("control", 32'h1, 32'(timerTwoControlIn));
		serialBTransmitOut <= 1'b0;
		serialRxEnable <= 1'b0;
		timerControlEnable <= 1'b0;
		timerClockOutEnable <= 1'b1;
		timerClockOut <= 1'b0;
		extOe <= 32'h0000_9000;
		settle();
		chk("tx", 32'h0, 32'(pinOut[13]));
		chk("rx idle", 32'h1, 32'(serialBReceiveIn));
		chk("control", 32'h0, 32'(timerTwoControlIn));
		chk("clockout", 32'h0, 32'(pinOut[14]));
		chk("alt pull", 32'h9, 32'(pinPullUp[15:12]));
		endTest("peripherals");
		extOe <= 32'hffff_00ff;
		extVal <= 32'h9669_0055;
		progCtl.verify <= 1'b1;
		settle();
		chk("prog low", 32'h0000_0069, 32'(progAddrLow));
		chk("bus read high", 32'h0000_0069, 32'(busReadHigh));
		chk("bus read low", 32'h0000_0055, 32'(busReadLow));
		chk("pin level", 32'h0000_0055, 32'(pinLevel[7:0]));
		chk("prog high", 32'h0000_0096, 32'(progAddrHigh));
		progCtl <= '{programming: 1'b1, verify: 1'b0};
		extVal <= 32'h3c00_0000;
		settle();
		chk("prog high", 32'h0000_003c, 32'(progAddrHigh));
		endTest("programming");
		complete_run();
	end
endmodule
